// File: acr_pkg.sv
// Package of constants, types and the register map for the converter configuration bank
package acr_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned ACR_NUM_REGS = 5;
    localparam int unsigned ACR_DATA_W = 8;
    localparam int unsigned ACR_ADDR_W = 3;
    localparam logic [2:0] ACR_ADDR_INPUT_GAIN = 3'h0;
    localparam logic [2:0] ACR_ADDR_RATE_MODE = 3'h1;
    localparam logic [2:0] ACR_ADDR_READY_CHECK = 3'h2;
    localparam logic [2:0] ACR_ADDR_CURRENT_ROUTE = 3'h3;
    localparam logic [2:0] ACR_ADDR_GENERAL_PIN = 3'h4;
    localparam logic [2:0] ACR_ADDR_LAST = 3'h4;
    localparam logic [7:0] ACR_RESET_VALUE = 8'h00;

    // Writable bit masks; zero bits are fixed zero or read-only
    localparam logic [7:0] ACR_WMASK_INPUT_GAIN = 8'hff;
    localparam logic [7:0] ACR_WMASK_RATE_MODE = 8'hff;
    localparam logic [7:0] ACR_WMASK_READY_CHECK = 8'h7f;
    localparam logic [7:0] ACR_WMASK_CURRENT_ROUTE = 8'hfd;
    localparam logic [7:0] ACR_WMASK_GENERAL_PIN = 8'h7f;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned ACR_SEL_HI = 7;
    localparam int unsigned ACR_SEL_LO = 4;
    localparam int unsigned ACR_GAIN_HI = 3;
    localparam int unsigned ACR_GAIN_LO = 1;
    localparam int unsigned ACR_BYPASS_BIT = 0;
    localparam int unsigned ACR_READY_BIT = 7;

    // ----------------------------------------------------------------
    // Selector and gain codes
    // ----------------------------------------------------------------
    localparam logic [3:0] ACR_SEL_DIFF_LAST = 4'h7;
    localparam logic [3:0] ACR_SEL_SE_FIRST = 4'h8;
    localparam logic [3:0] ACR_SEL_SE_LAST = 4'hb;
    localparam logic [3:0] ACR_SEL_REF_MON = 4'hc;
    localparam logic [3:0] ACR_SEL_SUP_MON = 4'hd;
    localparam logic [3:0] ACR_SEL_SHORT = 4'he;
    localparam logic [3:0] ACR_SEL_RESERVED = 4'hf;
    localparam logic [2:0] ACR_GAIN_MAX_BYPASSABLE = 3'h2;

    // Routing class decoded from the input selector
    typedef enum logic [2:0] {
        ACR_ROUTE_DIFF = 3'b000,
        ACR_ROUTE_SINGLE = 3'b001,
        ACR_ROUTE_REF_MON = 3'b010,
        ACR_ROUTE_SUP_MON = 3'b011,
        ACR_ROUTE_SHORT = 3'b100,
        ACR_ROUTE_RESERVED = 3'b101
    } acr_route_t;

endpackage

// File: acr_cfg_if.sv
// Interface carrying register 0 from the bank to its decoder
`timescale 1ns/1ps
interface acr_cfg_if;
    logic [7:0] cfg0;
    logic [2:0] pos_input;
    logic [2:0] neg_input;
    logic neg_is_supply;
    logic [2:0] route;
    logic [7:0] gain_factor;
    logic amp_enable;
    logic cap_gain;
    logic reserved_sel;
    logic host_misuse;

    modport bank (output cfg0, input pos_input, neg_input, neg_is_supply, route, gain_factor,
                  amp_enable, cap_gain, reserved_sel, host_misuse);
    modport dec (input cfg0, output pos_input, neg_input, neg_is_supply, route, gain_factor,
                 amp_enable, cap_gain, reserved_sel, host_misuse);
endinterface

// File: acr_input_gain_decode.sv
// Decoder of input selector, gain code and amplifier bypass
`timescale 1ns/1ps
module acr_input_gain_decode (
    acr_cfg_if.dec cfg
);
    import acr_pkg::*;

    // ----------------------------------------------------------------
    // Field extraction
    // ----------------------------------------------------------------
    wire [3:0] sel_code = cfg.cfg0[ACR_SEL_HI:ACR_SEL_LO];
    wire [2:0] gain_code = cfg.cfg0[ACR_GAIN_HI:ACR_GAIN_LO];
    wire bypass_req = cfg.cfg0[ACR_BYPASS_BIT];
    wire is_diff = (sel_code <= ACR_SEL_DIFF_LAST);
    wire is_single = (sel_code >= ACR_SEL_SE_FIRST) && (sel_code <= ACR_SEL_SE_LAST);
    wire is_monitor = (sel_code == ACR_SEL_REF_MON) || (sel_code == ACR_SEL_SUP_MON);
    wire low_gain = (gain_code <= ACR_GAIN_MAX_BYPASSABLE);

    // Differential pair table: positive and negative input numbers
    function automatic logic [5:0] diff_pair(input logic [2:0] c);
        unique case (c)
            3'h0: diff_pair = {3'h0, 3'h1};
            3'h1: diff_pair = {3'h0, 3'h2};
            3'h2: diff_pair = {3'h0, 3'h3};
            3'h3: diff_pair = {3'h1, 3'h0};
            3'h4: diff_pair = {3'h1, 3'h2};
            3'h5: diff_pair = {3'h1, 3'h3};
            3'h6: diff_pair = {3'h2, 3'h3};
            3'h7: diff_pair = {3'h3, 3'h2};
        endcase
    endfunction

    wire [5:0] pair = diff_pair(sel_code[2:0]);

    // ----------------------------------------------------------------
    // Routing outputs
    // ----------------------------------------------------------------
    // Eight pairs in order, then inputs 0..3 against the negative supply
    assign cfg.pos_input = is_diff ? pair[5:3] : {1'b0, sel_code[1:0]}; // R05
    assign cfg.neg_input = is_diff ? pair[2:0] : 3'h0; // R05
    assign cfg.neg_is_supply = is_single; // R05
    assign cfg.route = is_diff ? ACR_ROUTE_DIFF :
                       is_single ? ACR_ROUTE_SINGLE :
                       (sel_code == ACR_SEL_REF_MON) ? ACR_ROUTE_REF_MON : // R06
                       (sel_code == ACR_SEL_SUP_MON) ? ACR_ROUTE_SUP_MON : // R06
                       (sel_code == ACR_SEL_SHORT) ? ACR_ROUTE_SHORT : ACR_ROUTE_RESERVED; // R05
    assign cfg.reserved_sel = (sel_code == ACR_SEL_RESERVED); // R05

    // Gain is two to the code, 1 up to 128
    assign cfg.gain_factor = 8'h01 << gain_code; // R08

    // Amplifier off only when bypass is asked for a low gain, or a monitor is chosen;
    // high gains force it on whatever the bypass bit says
    assign cfg.amp_enable = !is_monitor && !(bypass_req && low_gain); // R06 R10 R11
    // Low gains without the amplifier come from the capacitor stage
    assign cfg.cap_gain = !cfg.amp_enable; // R09
    // Flags host setups that break the single-ended restriction; the device does not fix them
    assign cfg.host_misuse = is_single && !(bypass_req && low_gain); // R07

endmodule

// File: acr_config_bank.sv
// Top of the five-register configuration bank of the delta-sigma converter
//
// What this block does
// [R01] Five 8-bit registers at addresses 0 to 4 are read and written by register read and write commands.
// [R02] Power-up or any reset loads every register with zero.
// [R03] Power-down keeps every register unchanged so it is valid again on wake-up.
// [R04] Register 0 holds input selector in bits 7:4, gain code in 3:1 and bypass in bit 0, all read-write.
// [R05] Selector codes 0-7 pick the eight pairs, 8-11 inputs 0-3 against negative supply, 14 shorts, 15 reserved.
// [R06] Selector 12 monitors a quarter of the reference, 13 a quarter of the supply, both with amplifier bypassed.
// [R07] The host must set bypass and use gains 1, 2 or 4 for single-ended inputs against the negative supply.
// [R08] Gain code n selects gain two to the n, from 1 up to 128, default code zero.
// [R09] With the amplifier bypassed, gains 1, 2 and 4 are still produced by a capacitor stage.
// [R10] For gains 8 to 128 the amplifier stays enabled whatever the bypass bit says.
// [R11] Bypass bit zero enables the amplifier and one bypasses it, subject to the gain limit.
// [R12] Register 2 bit 7 is a read-only ready flag, set by a new result and cleared by a data read.
// [R13] Bits that are fixed zero always read zero and ignore writes.
`timescale 1ns/1ps
module acr_config_bank (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic power_down_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [acr_pkg::ACR_ADDR_W-1:0] reg_addr_in,
    input wire logic [acr_pkg::ACR_DATA_W-1:0] reg_wdata_in,
    input wire logic result_ready_in,
    input wire logic data_read_in,
    output logic [acr_pkg::ACR_DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic reg_addr_err_out,
    output logic [acr_pkg::ACR_DATA_W-1:0] cfg0_out,
    output logic [acr_pkg::ACR_DATA_W-1:0] cfg1_out,
    output logic [acr_pkg::ACR_DATA_W-1:0] cfg2_out,
    output logic [acr_pkg::ACR_DATA_W-1:0] cfg3_out,
    output logic [acr_pkg::ACR_DATA_W-1:0] cfg4_out,
    output logic conversion_ready_flag_out,
    output logic [2:0] positive_input_out,
    output logic [2:0] negative_input_out,
    output logic negative_supply_sel_out,
    output logic [2:0] route_out,
    output logic [7:0] gain_factor_out,
    output logic internal_amplifier_en_out,
    output logic cap_gain_out,
    output logic reserved_sel_out,
    output logic host_misuse_out
);
    import acr_pkg::*;

    // ----------------------------------------------------------------
    // Storage and decode
    // ----------------------------------------------------------------
    logic [ACR_DATA_W-1:0] regs_r [ACR_NUM_REGS];
    logic ready_r;
    logic [ACR_DATA_W-1:0] rdata_r;
    logic rvalid_r;
    logic addr_err_r;

    // Mask of writable bits for one address; used by write and read paths
    function automatic logic [7:0] wmask(input logic [2:0] a);
        unique case (a)
            ACR_ADDR_INPUT_GAIN: wmask = ACR_WMASK_INPUT_GAIN;
            ACR_ADDR_RATE_MODE: wmask = ACR_WMASK_RATE_MODE;
            ACR_ADDR_READY_CHECK: wmask = ACR_WMASK_READY_CHECK;
            ACR_ADDR_CURRENT_ROUTE: wmask = ACR_WMASK_CURRENT_ROUTE;
            ACR_ADDR_GENERAL_PIN: wmask = ACR_WMASK_GENERAL_PIN;
            default: wmask = 8'h00;
        endcase
    endfunction

    wire addr_ok = (reg_addr_in <= ACR_ADDR_LAST); // R01
    wire [7:0] wr_mask = wmask(reg_addr_in);
    // Power-down freezes every write so contents survive to wake-up
    wire wr_go = reg_write_in && addr_ok && !power_down_in; // R03
    wire [7:0] wr_val = reg_wdata_in & wr_mask; // R13

    // Read value: stored bits plus the live ready flag in register 2
    wire [7:0] ready_bits = {ready_r, 7'h00};
    wire [7:0] rd_stored = addr_ok ? (regs_r[reg_addr_in] & wr_mask) : 8'h00; // R13
    wire [7:0] rd_val = (reg_addr_in == ACR_ADDR_READY_CHECK) ? (rd_stored | ready_bits) : rd_stored; // R12

    // ----------------------------------------------------------------
    // Register array
    // ----------------------------------------------------------------
    // One writer per entry, generated; reset loads zero
    genvar gi;
    generate
        for (gi = 0; gi < ACR_NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge clk_in) begin
                if (!reset_n_in) begin
                    regs_r[gi] <= ACR_RESET_VALUE; // R02
                end else if (wr_go && (reg_addr_in == 3'(gi))) begin
                    regs_r[gi] <= wr_val; // R01 R04
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Ready flag
    // ----------------------------------------------------------------
    // A new result in the same cycle as a data read wins so no result is missed
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ready_r <= 1'b0; // R02
        end else if (result_ready_in) begin
            ready_r <= 1'b1; // R12
        end else if (data_read_in) begin
            ready_r <= 1'b0; // R12
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Answer one cycle after the read strobe; reads stay allowed in power-down
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            addr_err_r <= 1'b0;
        end else begin
            rvalid_r <= reg_read_in;
            addr_err_r <= (reg_read_in || reg_write_in) && !addr_ok;
            if (reg_read_in) begin
                rdata_r <= rd_val; // R01
            end
        end
    end

    // ----------------------------------------------------------------
    // Register 0 decode
    // ----------------------------------------------------------------
    acr_cfg_if cfg_bus ();
    assign cfg_bus.cfg0 = regs_r[ACR_ADDR_INPUT_GAIN]; // R04

    acr_input_gain_decode u_decode (
        .cfg(cfg_bus)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata_out = rdata_r;
    assign reg_rvalid_out = rvalid_r;
    assign reg_addr_err_out = addr_err_r;
    assign cfg0_out = regs_r[ACR_ADDR_INPUT_GAIN];
    assign cfg1_out = regs_r[ACR_ADDR_RATE_MODE];
    assign cfg2_out = (regs_r[ACR_ADDR_READY_CHECK] & ACR_WMASK_READY_CHECK) | ready_bits;
    assign cfg3_out = regs_r[ACR_ADDR_CURRENT_ROUTE] & ACR_WMASK_CURRENT_ROUTE;
    assign cfg4_out = regs_r[ACR_ADDR_GENERAL_PIN] & ACR_WMASK_GENERAL_PIN;
    assign conversion_ready_flag_out = ready_r;
    assign positive_input_out = cfg_bus.pos_input;
    assign negative_input_out = cfg_bus.neg_input;
    assign negative_supply_sel_out = cfg_bus.neg_is_supply;
    assign route_out = cfg_bus.route;
    assign gain_factor_out = cfg_bus.gain_factor;
    assign internal_amplifier_en_out = cfg_bus.amp_enable; // R10 R11
    assign cap_gain_out = cfg_bus.cap_gain; // R09
    assign reserved_sel_out = cfg_bus.reserved_sel;
    assign host_misuse_out = cfg_bus.host_misuse;

endmodule

// File: acr_config_bank_assertions.sv
// Concurrent checks on the configuration bank ports
`timescale 1ns/1ps
module acr_config_bank_assertions (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic power_down_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic result_ready_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic [7:0] cfg0_out,
    input wire logic [7:0] cfg1_out,
    input wire logic internal_amplifier_en_out,
    input wire logic [7:0] gain_factor_out,
    input wire logic conversion_ready_flag_out
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Selectors 12 and 13 are the monitors; they override the gain rule
    wire mon = cfg0_out[7:5] == 3'h6;
    property p_rd; reg_read_in |=> reg_rvalid_out; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_rd0; reg_read_in && reg_addr_in == 3'h0 |=> reg_rdata_out == $past(cfg0_out); endproperty
    a_rd0: assert property (p_rd0) else $error("read data wrong");
    property p_wr0; reg_write_in && !power_down_in && reg_addr_in == 3'h0 |=> cfg0_out == $past(reg_wdata_in);
    endproperty
    a_wr0: assert property (p_wr0) else $error("write not stored");
    property p_pd; power_down_in |=> $stable(cfg0_out) && $stable(cfg1_out); endproperty
    a_pd: assert property (p_pd) else $error("changed in power-down");
    property p_rst; $rose(reset_n_in) |-> cfg0_out == 8'h00 && cfg1_out == 8'h00 && !conversion_ready_flag_out;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
    property p_gain; gain_factor_out == 8'h01 << cfg0_out[3:1]; endproperty
    a_gain: assert property (p_gain) else $error("gain factor wrong");
    property p_hi; cfg0_out[3:1] > 3'h2 && !mon |-> internal_amplifier_en_out; endproperty
    a_hi: assert property (p_hi) else $error("amplifier off at high gain");
    property p_lo; cfg0_out[3:1] <= 3'h2 && !mon |-> internal_amplifier_en_out == !cfg0_out[0]; endproperty
    a_lo: assert property (p_lo) else $error("bypass not honoured");
    property p_mon; mon |-> !internal_amplifier_en_out; endproperty
    a_mon: assert property (p_mon) else $error("monitor not bypassed");
    property p_rdy; result_ready_in |=> conversion_ready_flag_out; endproperty
    a_rdy: assert property (p_rdy) else $error("ready flag not set");
    c_rd: cover property (reg_read_in ##1 reg_rvalid_out);
    c_pd: cover property (power_down_in && reg_write_in);
    c_mon: cover property (mon);
endmodule
bind acr_config_bank acr_config_bank_assertions i_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .power_down_in(power_down_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .result_ready_in(result_ready_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .cfg0_out(cfg0_out),
    .cfg1_out(cfg1_out), .internal_amplifier_en_out(internal_amplifier_en_out),
    .gain_factor_out(gain_factor_out), .conversion_ready_flag_out(conversion_ready_flag_out));

// File: acr_host_model.sv
// Host model that issues register read and write commands
`timescale 1ns/1ps
module acr_host_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    input wire logic err_in,
    output logic write_out = 1'b0,
    output logic read_out = 1'b0,
    output logic [2:0] addr_out = 3'h0,
    output logic [7:0] wdata_out = 8'h00
);
    // ----------------------------------------------------------------
    // Commands
    // ----------------------------------------------------------------
    // Strobe held across one taken edge; on release address and data are inverted so no stale value looks valid
    task automatic cmd(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q,
                       output logic v, output logic e);
        @(posedge clk_in);
        #1;
        write_out = w;
        read_out = !w;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        write_out = 1'b0;
        read_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
        q = rdata_in;
        v = rvalid_in;
        e = err_in;
    endtask
    // Single-ended input: bypass on and gain clamped to at most 4
    task automatic cfg_se(input logic [1:0] s, input logic [2:0] g);
        logic [7:0] q;
        logic v;
        logic e;
        cmd(1'b1, 3'h0, {2'b10, s, (g > 3'h2) ? 3'h2 : g, 1'b1}, q, v, e);
    endtask
endmodule

// File: acr_config_bank_tb_top.sv
// Self-checking testbench of the configuration bank
`timescale 1ns/1ps
module acr_config_bank_tb_top;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic clk_in, reset_n_in, power_down_in, result_ready_in, data_read_in;
    wire logic hw, hr, rvalid, err, flag, nsup, amp, cap, resv, misuse;
    wire logic [2:0] ha, pos, neg, route;
    wire logic [7:0] hd, rdata, gain, c0, c1, c2, c3, c4;
    logic [7:0] q;
    logic v, e;
    int n_fail = 0;
    int checks_done = 0;
    acr_host_model i_host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .err_in(err),
        .write_out(hw), .read_out(hr), .addr_out(ha), .wdata_out(hd));
    acr_config_bank i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .power_down_in(power_down_in),
        .reg_write_in(hw), .reg_read_in(hr), .reg_addr_in(ha), .reg_wdata_in(hd),
        .result_ready_in(result_ready_in), .data_read_in(data_read_in), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .reg_addr_err_out(err), .cfg0_out(c0), .cfg1_out(c1), .cfg2_out(c2),
        .cfg3_out(c3), .cfg4_out(c4), .conversion_ready_flag_out(flag), .positive_input_out(pos),
        .negative_input_out(neg), .negative_supply_sel_out(nsup), .route_out(route),
        .gain_factor_out(gain), .internal_amplifier_en_out(amp), .cap_gain_out(cap),
        .reserved_sel_out(resv), .host_misuse_out(misuse));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
        checks_done++;
        if (s !== x) begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_host.cmd(1'b1, a, d, q, v, e);
    endtask
    task automatic rd(input logic [2:0] a);
        i_host.cmd(1'b0, a, 8'h00, q, v, e);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Fixed-zero and read-only bits must drop out of an all-ones write
    task automatic t_regs;
        logic [7:0] m [5] = '{8'hff, 8'hff, 8'h7f, 8'hfd, 8'h7f};
        for (int i = 0; i < 5; i++) begin
            rd(3'(i));
            chk("reset", q, 8'h00);
            wr(3'(i), 8'hff);
            rd(3'(i));
            chk("ones", q, m[i]);
            chk("rvalid", v, 1);
            wr(3'(i), 8'h5a);
            rd(3'(i));
            chk("pattern", q, 8'h5a & m[i]);
            chk("cfg out", i == 0 ? c0 : i == 1 ? c1 : i == 2 ? c2 : i == 3 ? c3 : c4, 8'h5a & m[i]);
        end
        wr(3'h5, 8'h11);
        chk("write err", e, 1);
        rd(3'h7);
        chk("unmapped", q, 8'h00);
    endtask
    // Every selector code, with bypass set and gain 1
    task automatic t_sel;
        logic [2:0] pp [8] = '{0, 0, 0, 1, 1, 1, 2, 3};
        logic [2:0] nn [8] = '{1, 2, 3, 0, 2, 3, 3, 2};
        for (int s = 0; s < 16; s++) begin
            wr(3'h0, {4'(s), 4'h1});
            chk("route", route, s < 8 ? 3'h0 : s < 12 ? 3'h1 : 3'(s - 10));
            chk("neg supply", nsup, s >= 8 && s < 12);
            chk("reserved", resv, s == 15);
            chk("amp", amp, 0);
            if (s < 8) begin
                chk("pos", pos, pp[s]);
                chk("neg", neg, nn[s]);
            end else if (s < 12) begin
                chk("pos", pos, 3'(s - 8));
            end
        end
    endtask
    // Every gain code with the bypass bit clear and set
    task automatic t_gain;
        for (int g = 0; g < 8; g++) begin
            for (int b = 0; b < 2; b++) begin
                wr(3'h0, {4'h0, 3'(g), 1'(b)});
                chk("gain", gain, 8'h01 << g);
                chk("amp", amp, g > 2 || b == 0);
                chk("cap", cap, g <= 2 && b == 1);
            end
        end
        wr(3'h0, 8'h80);
        chk("misuse", misuse, 1);
        i_host.cfg_se(2'h1, 3'h5);
        chk("duty kept", misuse, 0);
        chk("cfg0 se", c0, 8'h95);
    endtask
    // Power-down holds contents; then ready flag, then a reset in mid-run
    task automatic t_pd_ready;
        wr(3'h1, 8'ha5);
        power_down_in = 1;
        wr(3'h1, 8'h3c);
        rd(3'h1);
        chk("pd hold", q, 8'ha5);
        power_down_in = 0;
        rd(3'h1);
        chk("wake", q, 8'ha5);
        @(posedge clk_in);
        #1 result_ready_in = 1;
        @(posedge clk_in);
        #1 result_ready_in = 0;
        wr(3'h2, 8'h00);
        rd(3'h2);
        chk("ready", q, 8'h80);
        chk("cfg2 ready", c2, 8'h80);
        // A new result and a data read in one cycle: the set must win
        result_ready_in = 1;
        data_read_in = 1;
        @(posedge clk_in);
        #1 result_ready_in = 0;
        chk("set wins", flag, 1);
        @(posedge clk_in);
        #1 data_read_in = 0;
        chk("cleared", flag, 0);
        reset_n_in = 0;
        repeat (2) @(posedge clk_in);
        #1 reset_n_in = 1;
        rd(3'h1);
        chk("rereset", q, 8'h00);
    endtask
    // ----------------------------------------------------------------
    // Clock, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_in = 0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        reset_n_in = 0;
        power_down_in = 0;
        result_ready_in = 0;
        data_read_in = 0;
        repeat (16) @(posedge clk_in);
        #1 reset_n_in = 1;
        t_regs;
        t_sel;
        t_gain;
        t_pd_ready;
        tally_and_finish;
    end
    // About 160 cycles are needed; give about thirty times that
    initial begin
        #200000;
        n_fail++;
        tally_and_finish;
    end
endmodule
